/* File: src/shadow_set_select.sv */
/*
  Holds the shadow register set selector of a processor core: control
  word, per-vector map and the current/previous set tracking.
  Assumes a core that pulses entry and return strobes on REF_CLK and an
  external controller whose set number is on the same clock.
*/
// The placing of the registers and the address-and-strobe port are this design's own decisions.
// Summary of operation
// RULE1 - Entry copies current set into previous set
// RULE2 - Return with boot vectors clear restores current
// RULE3 - Error level, debug, nested entries freeze sets
// RULE4 - Return under error level or boot vectors holds
// RULE5 - Current set is read only to software
// RULE6 - Software never writes previous above highest set (a write is stored without a check against HIGHEST_SET)
// RULE7 - Reserved bits read as zero
// RULE8 - Every allowed entry loads new current set
// RULE9 - Exceptions and plain interrupts use exception set
// RULE10 - Vectored interrupts use the per-vector map
// RULE11 - External mode uses the controller supplied set
// RULE12 - Exception set field is software writable
// RULE13 - Highest set field is preset and read only
// RULE14 - External mode latches controller set per interrupt
// RULE15 - No shadow sets holds both fields at zero
`timescale 1ns/1ps
`include "shadow_set_cfg.svh"

module shadow_set_select
  import shadow_set_pkg::*;
#(
  parameter logic [3:0] HIGHEST_SET = `HIGHEST_DEFAULT
)
(
  input  wire logic        REF_CLK,
  input  wire logic        RESET_N,
  input  wire logic [3:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR_STB,
  input  wire logic        RD_STB,
  output logic      [31:0] RDATA,
  input  wire logic        EXC_ENTRY,
  input  wire logic        INT_ENTRY,
  input  wire logic        SETS_ERROR_LEVEL,
  input  wire logic        DEBUG_ENTRY,
  input  wire logic        EXC_RETURN,
  input  wire logic        ERROR_LEVEL,
  input  wire logic        EXCEPTION_LEVEL,
  input  wire logic        BOOT_VECTORS,
  input  wire logic        VECTOR_SELECT,
  input  wire logic        EXT_INT_MODE,
  input  wire logic        VECTORED_INT_IMPL,
  input  wire logic [2:0]  VECTOR_NUMBER,
  input  wire logic [3:0]  EXT_CTRL_SET_IN,
  output logic      [3:0]  CURRENT_SET
);

  //**********************************************************************
  // State
  //**********************************************************************
  set_num_t    current_reg,   current_next;   // Current set number.
  set_num_t    previous_reg,  previous_next;  // Previous set number.
  set_num_t    exception_reg, exception_next; // Set for plain entries.
  set_num_t    ext_ctrl_reg,  ext_ctrl_next;  // Controller supplied set.
  logic [31:0] map_reg,       map_next;       // Per-vector set map.
  logic [31:0] rdata_reg,     rdata_next;     // Registered read data.
  entry_t      entry;                         // Kind of entry now.
  logic        frozen;                        // Entry may not touch sets.
  set_num_t    new_set;                       // Set chosen for the entry.
  logic        have_sets;                     // Shadow sets exist.

  // Picks one four-bit map field by vector number.
  function automatic set_num_t map_field(input logic [31:0] map,
                                         input logic [2:0]  idx);
    map_field = map[{idx, 2'b00} +: 4];
  endfunction

  // Builds the control word with reserved bits as zero.
  function automatic logic [31:0] control_word(input set_num_t cur,
    input set_num_t prev, input set_num_t exc, input set_num_t ext,
    input set_num_t hi);
    control_word = 32'h0000_0000;
    control_word[`POS_CURRENT +: 4]   = cur;
    control_word[`POS_PREVIOUS +: 4]  = prev;
    control_word[`POS_EXCEPTION +: 4] = exc;
    control_word[`POS_EXT_CTRL +: 4]  = ext;
    control_word[`POS_HIGHEST +: 4]   = hi;
  endfunction

  //**********************************************************************
  // Entry classification and set choice
  //**********************************************************************
  // Decides what kind of entry happens and which set it selects.
  always_comb
  begin
    have_sets = (HIGHEST_SET != 4'h0);
    if (INT_ENTRY)
      entry = ENTRY_INT;
    else if (EXC_ENTRY)
      entry = ENTRY_EXC;
    else
      entry = ENTRY_NONE;
    // Error-level entries, debug entry and nested entries leave sets.
    frozen = SETS_ERROR_LEVEL || DEBUG_ENTRY || EXCEPTION_LEVEL ||
             BOOT_VECTORS; // RULE3
    // Exceptions and non-vectored interrupts use the exception set.
    new_set = exception_reg; // RULE9
    if (entry == ENTRY_INT && VECTOR_SELECT)
    begin
      if (EXT_INT_MODE)
        new_set = EXT_CTRL_SET_IN; // RULE11
      else if (VECTORED_INT_IMPL)
        new_set = map_field(map_reg, VECTOR_NUMBER); // RULE10
    end
  end

  //**********************************************************************
  // Next state of the set fields and registers
  //**********************************************************************
  // Merges software writes with hardware entry and return updates.
  always_comb
  begin
    current_next   = current_reg;
    previous_next  = previous_reg;
    exception_next = exception_reg;
    ext_ctrl_next  = ext_ctrl_reg;
    map_next       = map_reg;
    rdata_next     = 32'h0000_0000;
    // Software writes; the current field ignores writes.
    if (WR_STB && ADDR == `OFS_SET_CONTROL)
    begin
      previous_next  = WDATA[`POS_PREVIOUS +: 4]; // RULE1
      exception_next = WDATA[`POS_EXCEPTION +: 4]; // RULE12
    end
    else if (WR_STB && ADDR == `OFS_VECTOR_MAP)
      map_next = WDATA;
    // Controller set is latched on each interrupt in external mode.
    if (entry == ENTRY_INT && EXT_INT_MODE)
      ext_ctrl_next = EXT_CTRL_SET_IN; // RULE14
    // Hardware entry wins over a software write in the same cycle.
    if (entry != ENTRY_NONE && !frozen)
    begin
      previous_next = current_reg; // RULE1
      current_next  = new_set; // RULE8
    end
    // A return under error level or boot vectors keeps current.
    else if (EXC_RETURN && !ERROR_LEVEL && !BOOT_VECTORS) // RULE4
      current_next = previous_next; // RULE2 RULE5
    if (!have_sets)
    begin
      current_next  = 4'h0; // RULE15
      previous_next = 4'h0; // RULE15
    end
    // Reads of unmapped offsets return zero.
    if (RD_STB && ADDR == `OFS_SET_CONTROL)
      rdata_next = control_word(current_reg, previous_reg, exception_reg,
        EXT_INT_MODE ? ext_ctrl_reg : 4'h0, HIGHEST_SET); // RULE7 RULE13
    else if (RD_STB && ADDR == `OFS_VECTOR_MAP)
      rdata_next = map_reg;
  end

  //**********************************************************************
  // Registers
  //**********************************************************************
  // Registers every field with a synchronous active-low reset.
  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      current_reg   <= `SET_RESET;
      previous_reg  <= `SET_RESET;
      exception_reg <= `SET_RESET;
      ext_ctrl_reg  <= `SET_RESET;
      map_reg       <= 32'h0000_0000;
      rdata_reg     <= 32'h0000_0000;
    end
    else
    begin
      current_reg   <= current_next;
      previous_reg  <= previous_next;
      exception_reg <= exception_next;
      ext_ctrl_reg  <= ext_ctrl_next;
      map_reg       <= map_next;
      rdata_reg     <= rdata_next;
    end
  end

  // Outputs come straight from flip-flops.
  assign RDATA       = rdata_reg;
  assign CURRENT_SET = current_reg;

  //**********************************************************************
  // Assertions
  //**********************************************************************
  // Entry saves the old current set before loading a new one.
  a_entry_saves_prev: assert property (@(posedge REF_CLK) // RULE1
    disable iff (!RESET_N)
    (INT_ENTRY || EXC_ENTRY) && !frozen && HIGHEST_SET != 4'h0
    |=> previous_reg == $past(current_reg))
    else $error("Previous set not saved on entry.");

  // A write in the same cycle changes what return copies, so it is left
  // out here; the merge order in the next-state logic covers that case.
  a_return_restores: assert property (@(posedge REF_CLK) // RULE2
    disable iff (!RESET_N)
    EXC_RETURN && !INT_ENTRY && !EXC_ENTRY && !ERROR_LEVEL &&
    !BOOT_VECTORS && !WR_STB |=> current_reg == $past(previous_reg))
    else $error("Return did not restore current set.");

  // Frozen entries leave the current set alone.
  a_frozen_entry: assert property (@(posedge REF_CLK) // RULE3
    disable iff (!RESET_N)
    (INT_ENTRY || EXC_ENTRY) && frozen && !EXC_RETURN
    |=> $stable(current_reg))
    else $error("Frozen entry changed current set.");

  // Frozen entries leave the previous set alone unless software writes.
  a_frozen_keeps_prev: assert property (@(posedge REF_CLK) // RULE3
    disable iff (!RESET_N)
    (INT_ENTRY || EXC_ENTRY) && frozen && !WR_STB
    |=> $stable(previous_reg))
    else $error("Frozen entry changed previous set.");

  // A held return keeps the current set.
  a_return_held: assert property (@(posedge REF_CLK) // RULE4
    disable iff (!RESET_N)
    EXC_RETURN && (ERROR_LEVEL || BOOT_VECTORS) &&
    !INT_ENTRY && !EXC_ENTRY |=> $stable(current_reg))
    else $error("Return changed current set while held.");

  // Without entry or return the current set never moves.
  a_cur_read_only: assert property (@(posedge REF_CLK) // RULE5
    disable iff (!RESET_N)
    !INT_ENTRY && !EXC_ENTRY && !EXC_RETURN |=> $stable(current_reg))
    else $error("Current set changed without cause.");

  // Reset clears both set fields; it has no disable term on purpose.
  a_reset_clears: assert property (@(posedge REF_CLK) // RULE8
    !RESET_N |=> current_reg == 4'h0 && previous_reg == 4'h0)
    else $error("Reset left a set field nonzero.");

  // Reserved bits of the control word read as zero. The map word has
  // no reserved bits, so only control reads are watched.
  a_reserved_zero: assert property (@(posedge REF_CLK) // RULE7
    disable iff (!RESET_N)
    RD_STB && ADDR == `OFS_SET_CONTROL
    |=> RDATA[31:30] == 2'h0 && RDATA[25:22] == 4'h0 &&
    RDATA[17:16] == 2'h0 && RDATA[11:10] == 2'h0 && RDATA[5:4] == 2'h0)
    else $error("Reserved bits read as nonzero.");

  // The preset highest set number shows in every control read.
  a_highest_read: assert property (@(posedge REF_CLK) // RULE13
    disable iff (!RESET_N)
    RD_STB && ADDR == `OFS_SET_CONTROL
    |=> RDATA[`POS_HIGHEST +: 4] == HIGHEST_SET)
    else $error("Highest set field read wrong.");

  // A control write always lands in the exception set field.
  a_exc_set_write: assert property (@(posedge REF_CLK) // RULE12
    disable iff (!RESET_N)
    WR_STB && ADDR == `OFS_SET_CONTROL
    |=> exception_reg == $past(WDATA[`POS_EXCEPTION +: 4]))
    else $error("Exception set field not written.");

  // Plain exceptions load the exception set.
  a_exc_set_used: assert property (@(posedge REF_CLK) // RULE9
    disable iff (!RESET_N)
    EXC_ENTRY && !INT_ENTRY && !frozen && HIGHEST_SET != 4'h0
    |=> current_reg == $past(exception_reg))
    else $error("Exception did not load exception set.");

  // Interrupts with vector select clear are treated as exceptions.
  a_plain_int_set: assert property (@(posedge REF_CLK) // RULE9
    disable iff (!RESET_N)
    INT_ENTRY && !VECTOR_SELECT && !frozen && HIGHEST_SET != 4'h0
    |=> current_reg == $past(exception_reg))
    else $error("Plain interrupt did not load exception set.");

  // Vectored interrupts take the map field picked by the vector number.
  a_vector_map_set: assert property (@(posedge REF_CLK) // RULE10
    disable iff (!RESET_N)
    INT_ENTRY && VECTOR_SELECT && !EXT_INT_MODE && VECTORED_INT_IMPL &&
    !frozen && HIGHEST_SET != 4'h0
    |=> current_reg == $past(map_reg[VECTOR_NUMBER * 4 +: 4]))
    else $error("Vectored interrupt did not use map field.");

  // External mode takes the controller's set number.
  a_ext_uses_ctrl: assert property (@(posedge REF_CLK) // RULE11
    disable iff (!RESET_N)
    INT_ENTRY && VECTOR_SELECT && EXT_INT_MODE && !frozen &&
    HIGHEST_SET != 4'h0 |=> current_reg == $past(EXT_CTRL_SET_IN))
    else $error("External mode did not use controller set.");

  // The controller's set is latched on every interrupt in external mode,
  // frozen or not, so control reads in external mode show what was last offered.
  a_ext_latch: assert property (@(posedge REF_CLK) // RULE14
    disable iff (!RESET_N)
    INT_ENTRY && EXT_INT_MODE |=> ext_ctrl_reg == $past(EXT_CTRL_SET_IN))
    else $error("Controller set not latched.");

  // Read data stands for one cycle only and is zero otherwise.
  a_rdata_idle: assert property (@(posedge REF_CLK)
    disable iff (!RESET_N)
    !RD_STB |=> RDATA == 32'h0000_0000)
    else $error("Read data stood without a read.");

endmodule

/* File: src/shadow_set_cfg.svh */
/*
  Holds the offsets, field positions and reset values of the shadow set
  selector as macros. Assumes it is included by bare name, once or more.
*/
`ifndef SHADOW_SET_CFG_SVH
`define SHADOW_SET_CFG_SVH

// Register offsets on the plain register port.
`define OFS_SET_CONTROL  4'h0
`define OFS_VECTOR_MAP   4'h1
// Field positions inside the control word.
`define POS_CURRENT      0
`define POS_PREVIOUS     6
`define POS_EXCEPTION    12
`define POS_EXT_CTRL     18
`define POS_HIGHEST      26
// Reset value of every writable set field.
`define SET_RESET        4'h0
// Preset highest implemented set number.
`define HIGHEST_DEFAULT  4'hf

`endif

/* File: src/shadow_set_pkg.sv */
/*
  Holds the types of the shadow set selector. Assumes nothing else.
*/
package shadow_set_pkg;
  // A shadow set number.
  typedef logic [3:0] set_num_t;
  // Kind of kernel entry being taken.
  typedef enum logic [1:0] {ENTRY_NONE, ENTRY_EXC, ENTRY_INT} entry_t;
endpackage

/* File: verification/ext_ctrl_model.sv */
/*
  Model of the external interrupt controller that hands over a set number.
  Assumes the core clock and a one-cycle interrupt entry pulse.
*/
`timescale 1ns/1ps

module ext_ctrl_model
  import shadow_set_pkg::*;
(
  input  wire logic clk,
  input  wire logic int_req,
  input  wire set_num_t set_cfg,
  output set_num_t set_out
);
  // Last value shown, so that idle cycles show its inverse.
  set_num_t last_reg = 4'h0;

  // The set number is valid only beside a request, never left standing.
  assign set_out = int_req ? set_cfg : ~last_reg;

  // Remember what was shown in this cycle.
  always_ff @(posedge clk)
    last_reg <= set_out;
endmodule

/* File: verification/shadow_set_select_bench.sv */
/*
  Self-checking bench for the shadow set selector.
  Assumes the default preset highest set number of 4'hf.
*/
`timescale 1ns/1ps

module shadow_set_select_bench
  import shadow_set_pkg::*;
;
  // ****************************************
  // Stimulus signals and counters.
  // ****************************************
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic [4:0]  ev = 5'h00;
  logic [5:0]  lv = 6'h00;
  logic [2:0]  vnum = 3'h3;
  set_num_t    cfg = 4'h3;
  set_num_t    ext_set;
  set_num_t    cur;
  int          failures = 0;
  int          samples_checked = 0;

  // The clock toggles every half period of 100 ns.
  always #50 clk = ~clk;

  shadow_set_select shadow_set_select_i (.REF_CLK(clk), .RESET_N(rst_n),
    .ADDR(addr), .WDATA(wdata), .WR_STB(wr), .RD_STB(rd), .RDATA(rdata),
    .EXC_ENTRY(ev[4]), .INT_ENTRY(ev[3]), .SETS_ERROR_LEVEL(ev[2]),
    .DEBUG_ENTRY(ev[1]), .EXC_RETURN(ev[0]), .ERROR_LEVEL(lv[5]),
    .EXCEPTION_LEVEL(lv[4]), .BOOT_VECTORS(lv[3]), .VECTOR_SELECT(lv[2]),
    .EXT_INT_MODE(lv[1]), .VECTORED_INT_IMPL(lv[0]),
    .VECTOR_NUMBER(vnum), .EXT_CTRL_SET_IN(ext_set), .CURRENT_SET(cur));

  ext_ctrl_model ext_ctrl_model_i (.clk(clk), .int_req(ev[3]),
    .set_cfg(cfg), .set_out(ext_set));

  // ****************************************
  // Compare, bus and event tasks.
  // ****************************************
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compares a current set number.
  task automatic cmp_set(input set_num_t got, input set_num_t exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // A write is one strobe cycle.
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe.
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 cmp32(rdata, exp);
  endtask

  // Pulse entry or return strobes under given levels, then check the set.
  task automatic pulse(input logic [5:0] l, input logic [4:0] e,
                       input set_num_t exp);
    @(posedge clk);
    lv <= l;
    ev <= e;
    @(posedge clk);
    ev <= 5'h00;
    #1 cmp_set(cur, exp);
  endtask

  // ****************************************
  // Scenarios.
  // ****************************************
  // Reset values, reserved and read-only bits.
  task automatic t_regs();
    rd_reg(4'h0, 32'h3c00_0000);
    wr_reg(4'h0, 32'h3c00_f3cf);
    rd_reg(4'h0, 32'h3c00_f3c0);
    wr_reg(4'h0, 32'h0000_5000);
    wr_reg(4'h1, 32'h6000_a000);
    rd_reg(4'h1, 32'h6000_a000);
  endtask

  // Every source of a new current set, with previous set tracking.
  task automatic t_sources();
    pulse(6'h00, 5'h10, 4'h5);
    pulse(6'h05, 5'h08, 4'ha);
    rd_reg(4'h0, 32'h3c00_514a);
    pulse(6'h07, 5'h08, 4'h3);
    rd_reg(4'h0, 32'h3c0c_5283);
    @(posedge clk);
    vnum <= 3'h7;
    pulse(6'h05, 5'h08, 4'h6);
    pulse(6'h00, 5'h08, 4'h5);
  endtask

  // Entries that must leave both fields alone.
  task automatic t_freeze();
    logic [5:0] ls [4] = '{6'h10, 6'h08, 6'h00, 6'h00};
    logic [4:0] es [4] = '{5'h10, 5'h10, 5'h14, 5'h12};
    for (int i = 0; i < 4; i++)
      pulse(ls[i], es[i], 4'h5);
    rd_reg(4'h0, 32'h3c00_5185);
  endtask

  // Held returns, then a return that restores the previous set.
  task automatic t_return();
    pulse(6'h20, 5'h01, 4'h5);
    pulse(6'h08, 5'h01, 4'h5);
    pulse(6'h00, 5'h01, 4'h6);
  endtask

  // A reset in mid-run returns every field to its reset value.
  task automatic t_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1 cmp_set(cur, 4'h0);
    rd_reg(4'h0, 32'h3c00_0000);
    rd_reg(4'h1, 32'h0000_0000);
  endtask

  // Print the counts and the verdict, then end the run.
  task automatic report_and_stop();
    $display("checked=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence after five reset cycles.
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_sources();
    t_freeze();
    t_return();
    t_reset();
    report_and_stop();
  end

  // Watchdog cuts a hang short well after the tests should end.
  initial
  begin
    #200000;
    failures++;
    report_and_stop();
  end
endmodule
